// ===== design/tmr_half.sv
// One timer half: count, period end, output pulse or toggle
`timescale 1ns/1ps
module tmr_half (
  input wire logic hclk,
  input wire logic hresetn,
  tmr_half_if.half hif
);
  typedef struct packed {
    logic [31:0] cnt;
    logic act;
    logic pin;
    logic running;
  } tmr_half_s;
  tmr_half_s st_reg;
  tmr_half_s st_next;
  logic [31:0] mask;
  logic oneshot;
  logic counting;
  logic hit;

  always_comb begin
    mask = hif.wide ? 32'hffff_ffff : tmr_pkg::MASK16;
    oneshot = hif.mode == tmr_pkg::MODE_ONESHOT;
    counting = oneshot || (hif.mode == tmr_pkg::MODE_CONT);
    hit = st_reg.cnt == (hif.cmp & mask);
    hif.end_evt = counting && st_reg.running && hif.en && hif.tick && hit;
    hif.done = hif.end_evt && oneshot;
    st_next = st_reg;
    // One-shot pulse lasts a single source clock
    if (oneshot && st_reg.act) begin
      st_next.act = 1'b0;
    end
    if (hif.ld) begin
      st_next.cnt = hif.ld_val & mask;
    end else if (hif.end_evt) begin
      st_next.cnt = tmr_pkg::CNT_RELOAD;
      if (oneshot) begin
        st_next.act = 1'b1;
      end else begin
        st_next.act = ~st_reg.act;
      end
    end else if (counting && st_reg.running && hif.en && hif.tick) begin
      st_next.cnt = (st_reg.cnt + 32'h0000_0001) & mask;
    end
    st_next.running = hif.en && !hif.done;
    st_next.pin = hif.pol ^ st_next.act;
    hif.cnt = st_reg.cnt;
    hif.running = st_reg.running;
    hif.pin = st_reg.pin;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ===== design/tmr_half_if.sv
// Interface between register block and one timer half
`timescale 1ns/1ps
interface tmr_half_if;
  logic tick;
  logic en;
  logic pol;
  logic wide;
  logic ld;
  logic [3:0] mode;
  logic [31:0] cmp;
  logic [31:0] ld_val;
  logic [31:0] cnt;
  logic running;
  logic end_evt;
  logic done;
  logic pin;
  modport ctl (output tick, en, pol, wide, ld, mode, cmp, ld_val,
    input cnt, running, end_evt, done, pin);
  modport half (input tick, en, pol, wide, ld, mode, cmp, ld_val,
    output cnt, running, end_evt, done, pin);
endinterface

// ===== design/tmr_pkg.sv
// Package of register map, field positions and modes for the timer
package tmr_pkg;
  localparam logic [7:0] OFS_COUNT = 8'h00;
  localparam logic [7:0] OFS_COMPARE = 8'h04;
  localparam logic [7:0] OFS_PCTRL = 8'h08;
  localparam logic [7:0] OFS_SCTRL = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam int HALF_B_SHIFT = 16;
  // Primary control fields, per half
  localparam int MODE_LSB = 0;
  localparam int DIV_LSB = 4;
  localparam int POL_BIT = 8;
  localparam int EN_BIT = 9;
  localparam int CLKEN_BIT = 10;
  localparam logic [31:0] PCTRL_WMASK = 32'h07ff_07ff;
  localparam logic [31:0] PCTRL_RESET = 32'h0000_0000;
  // Secondary control fields, per half, and the single cascade bit
  localparam int RDY_BIT = 0;
  localparam int IE_BIT = 1;
  localparam int OUTEN_BIT = 2;
  localparam int OUTBEN_BIT = 3;
  localparam int CASCADE_BIT = 31;
  localparam logic [31:0] SCTRL_WMASK = 32'h800e_000e;
  localparam logic [31:0] SCTRL_RESET = 32'h0000_0000;
  // Event flag fields
  localparam int IRQ_A_BIT = 0;
  localparam int WRDONE_BIT = 8;
  localparam int IRQ_B_BIT = 16;
  // Count values
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_RELOAD = 32'h0000_0001;
  localparam logic [31:0] CMP_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK16 = 32'h0000_ffff;
  localparam logic [3:0] DIV_MAX = 4'hc;
  // Mode codes
  localparam logic [3:0] MODE_ONESHOT = 4'h0;
  localparam logic [3:0] MODE_CONT = 4'h1;
  localparam logic [3:0] MODE_COUNTER = 4'h2;
  localparam logic [3:0] MODE_PWM = 4'h3;
  localparam logic [3:0] MODE_CAPTURE = 4'h4;
  localparam logic [3:0] MODE_COMPARE = 4'h5;
  localparam logic [3:0] MODE_GATED = 4'h6;
  localparam logic [3:0] MODE_CAPCMP = 4'h7;
  localparam logic [3:0] MODE_DUALEDGE = 4'h8;
  localparam logic [3:0] MODE_INACT_GATED = 4'he;
endpackage

// ===== design/tmr_presc.sv
// Prescaler giving a one-cycle counting tick every 2^div clocks, div capped at 12
`timescale 1ns/1ps
module tmr_presc (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] div,
  input wire logic run,
  output logic tick
);
  typedef struct packed {
    logic [11:0] cnt;
  } tmr_presc_s;
  tmr_presc_s st_reg;
  tmr_presc_s st_next;
  logic [3:0] code;
  logic [11:0] limit;

  always_comb begin
    code = (div > tmr_pkg::DIV_MAX) ? tmr_pkg::DIV_MAX : div;
    limit = 12'((13'h0001 << code) - 13'h0001);
    tick = run && (st_reg.cnt == limit);
    st_next = st_reg;
    if (!run || tick) begin
      st_next.cnt = 12'h000;
    end else begin
      st_next.cnt = st_reg.cnt + 12'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ===== design/tmr_top.sv
// Timer top: AHB-Lite registers, two halves, pins and interrupt
//
// Summary of operation
// - Mode field: 0 one-shot, 1 continuous, 2..8 others, 14 inactive gated.
// - Standard instance: each half has true and complementary output pins.
// - Low-power instance: only half A, on the B pin, no complement.
// - One-shot counts up to compare, then disables itself.
// - One-shot output goes active for exactly one source clock.
// - One-shot end: count to one, enable cleared, pulse, flag set.
// - One-shot period ends on the tick after count equals compare.
// - Reset clears count to zero; later periods start at one.
// - Written initial count affects only the first period.
// - Count writes take effect only while the clock enable is set.
// - Write-done flag rises once a count write took effect.
// - Enable bit reads back one once the timer runs.
// - Continuous mode reloads one on match and keeps counting.
// - Continuous mode toggles the output every period end.
// - Continuous reload happens on the tick after the match.
// - Continuous flag sets together with the output toggle.
// - Polarity gives the inactive output level.
// - Inverted output is the complement, same polarity setting.
// - Interrupt request gated by enable field; flag still set.
// - Cascade bit joins halves A and B into one 32-bit timer.
// - Counting clock is source clock divided by 1 to 4096.
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module tmr_top #(
  parameter bit LOW_POWER = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic half_a_pin_o,
  output logic half_a_pin_oe,
  output logic half_a_inverted_pin_o,
  output logic half_a_inverted_pin_oe,
  output logic half_b_pin_o,
  output logic half_b_pin_oe,
  output logic half_b_inverted_pin_o,
  output logic half_b_inverted_pin_oe,
  output logic irq
);
  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] cmp;
    logic [31:0] pctrl;
    logic [31:0] sctrl;
    logic [31:0] rdata;
    logic [1:0] rdy;
    logic [1:0] ld_seen;
    logic wrdone;
    logic [1:0] flag;
  } tmr_top_s;
  tmr_top_s st_reg;
  tmr_top_s st_next;

  tmr_half_if hif [2] ();

  logic cascade;
  logic ap_valid;
  logic wr_count;
  logic [1:0] ld_go;
  logic [1:0] running_w;
  logic [1:0] evt_w;
  logic [1:0] done_w;
  logic [1:0] pin_w;
  logic [1:0] clken_w;
  logic [1:0] ie_w;
  logic [31:0] cnt_w [2];
  logic [31:0] en_bits;
  logic [31:0] rdy_bits;
  logic [31:0] rd_mux;
  logic [31:0] w1c;

  assign cascade = st_reg.sctrl[tmr_pkg::CASCADE_BIT];
  assign ap_valid = hsel && hready && htrans[1];
  assign wr_count = st_reg.wr_pend && (st_reg.wr_addr == tmr_pkg::OFS_COUNT);

  generate
    for (genvar h = 0; h < 2; h++) begin : g_half
      localparam int S = h * tmr_pkg::HALF_B_SHIFT;
      assign clken_w[h] = st_reg.pctrl[S + tmr_pkg::CLKEN_BIT];
      assign ie_w[h] = st_reg.sctrl[S + tmr_pkg::IE_BIT];
      // Count write needs the clock enable of its half
      assign ld_go[h] = wr_count && clken_w[h] && !(h == 1 && cascade);
      assign hif[h].ld = ld_go[h];
      assign hif[h].ld_val = (h == 0) ? hwdata : {16'h0000, hwdata[31:16]};
      assign hif[h].mode = st_reg.pctrl[S + tmr_pkg::MODE_LSB +: 4];
      assign hif[h].pol = st_reg.pctrl[S + tmr_pkg::POL_BIT];
      // Half B stands still while cascaded into A
      assign hif[h].en = st_reg.pctrl[S + tmr_pkg::EN_BIT] && clken_w[h]
        && !(h == 1 && cascade);
      assign hif[h].wide = (h == 0) && cascade;
      assign hif[h].cmp = (h == 0) ? st_reg.cmp : {16'h0000, st_reg.cmp[31:16]};
      assign running_w[h] = hif[h].running;
      assign evt_w[h] = hif[h].end_evt;
      assign done_w[h] = hif[h].done;
      assign pin_w[h] = hif[h].pin;
      assign cnt_w[h] = hif[h].cnt;
      assign en_bits[S + tmr_pkg::EN_BIT] = running_w[h];
      assign rdy_bits[S + tmr_pkg::RDY_BIT] = st_reg.rdy[h];
      tmr_presc u_presc (
        .hclk(hclk),
        .hresetn(hresetn),
        .div(st_reg.pctrl[S + tmr_pkg::DIV_LSB +: 4]),
        .run(running_w[h]),
        .tick(hif[h].tick)
      );
      tmr_half u_half (
        .hclk(hclk),
        .hresetn(hresetn),
        .hif(hif[h])
      );
    end
  endgenerate

  // Remaining bits of the read-back overlays are zero
  assign en_bits[8:0] = 9'h000;
  assign en_bits[24:10] = 15'h0000;
  assign en_bits[31:26] = 6'h00;
  assign rdy_bits[15:1] = 15'h0000;
  assign rdy_bits[31:17] = 15'h0000;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      tmr_pkg::OFS_COUNT: begin
        rd_mux = cascade ? cnt_w[0] : {cnt_w[1][15:0], cnt_w[0][15:0]};
      end
      tmr_pkg::OFS_COMPARE: begin
        rd_mux = st_reg.cmp;
      end
      tmr_pkg::OFS_PCTRL: begin
        rd_mux = (st_reg.pctrl & ~en_bits & ~32'h0200_0200) | en_bits;
      end
      tmr_pkg::OFS_SCTRL: begin
        rd_mux = st_reg.sctrl | rdy_bits;
      end
      tmr_pkg::OFS_FLAGS: begin
        rd_mux[tmr_pkg::IRQ_A_BIT] = st_reg.flag[0];
        rd_mux[tmr_pkg::IRQ_B_BIT] = st_reg.flag[1];
        rd_mux[tmr_pkg::WRDONE_BIT] = st_reg.wrdone;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    st_next = st_reg;
    w1c = 32'h0000_0000;
    st_next.wr_pend = ap_valid && hwrite;
    if (ap_valid) begin
      st_next.wr_addr = haddr[7:0];
    end
    if (ap_valid && !hwrite) begin
      st_next.rdata = rd_mux;
    end
    if (st_reg.wr_pend) begin
      case (st_reg.wr_addr)
        tmr_pkg::OFS_COMPARE: begin
          st_next.cmp = hwdata;
        end
        tmr_pkg::OFS_PCTRL: begin
          st_next.pctrl = hwdata & tmr_pkg::PCTRL_WMASK;
        end
        tmr_pkg::OFS_SCTRL: begin
          st_next.sctrl = hwdata & tmr_pkg::SCTRL_WMASK;
        end
        tmr_pkg::OFS_FLAGS: begin
          w1c = hwdata;
        end
        default: begin
          w1c = 32'h0000_0000;
        end
      endcase
    end
    // One-shot end clears the enable bit of its half
    if (done_w[0]) begin
      st_next.pctrl[tmr_pkg::EN_BIT] = 1'b0;
    end
    if (done_w[1]) begin
      st_next.pctrl[tmr_pkg::HALF_B_SHIFT + tmr_pkg::EN_BIT] = 1'b0;
    end
    st_next.rdy = clken_w;
    st_next.ld_seen = ld_go;
    // Write-done drops on a new count write, rises once the count took it
    st_next.wrdone = (st_reg.wrdone && !w1c[tmr_pkg::WRDONE_BIT] && !(|ld_go))
      || (|st_reg.ld_seen);
    // Hardware set wins over a same-cycle clear
    st_next.flag[0] = (st_reg.flag[0] && !w1c[tmr_pkg::IRQ_A_BIT]) || evt_w[0];
    st_next.flag[1] = (st_reg.flag[1] && !w1c[tmr_pkg::IRQ_B_BIT]) || evt_w[1];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg.wr_pend <= 1'b0;
      st_reg.wr_addr <= 8'h00;
      st_reg.cmp <= tmr_pkg::CMP_RESET;
      st_reg.pctrl <= tmr_pkg::PCTRL_RESET;
      st_reg.sctrl <= tmr_pkg::SCTRL_RESET;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.rdy <= 2'b00;
      st_reg.ld_seen <= 2'b00;
      st_reg.wrdone <= 1'b0;
      st_reg.flag <= 2'b00;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = (st_reg.flag[0] && ie_w[0]) || (st_reg.flag[1] && ie_w[1]);

  // Pin mapping by instance kind
  always_comb begin
    if (LOW_POWER) begin
      half_a_pin_o = 1'b0;
      half_a_pin_oe = 1'b0;
      half_a_inverted_pin_o = 1'b0;
      half_a_inverted_pin_oe = 1'b0;
      half_b_pin_o = pin_w[0];
      half_b_pin_oe = st_reg.sctrl[tmr_pkg::OUTEN_BIT];
      half_b_inverted_pin_o = 1'b0;
      half_b_inverted_pin_oe = 1'b0;
    end else begin
      half_a_pin_o = pin_w[0];
      half_a_pin_oe = st_reg.sctrl[tmr_pkg::OUTEN_BIT];
      half_a_inverted_pin_o = ~pin_w[0];
      half_a_inverted_pin_oe = st_reg.sctrl[tmr_pkg::OUTBEN_BIT];
      half_b_pin_o = pin_w[1];
      half_b_pin_oe = st_reg.sctrl[tmr_pkg::HALF_B_SHIFT + tmr_pkg::OUTEN_BIT];
      half_b_inverted_pin_o = ~pin_w[1];
      half_b_inverted_pin_oe = st_reg.sctrl[tmr_pkg::HALF_B_SHIFT + tmr_pkg::OUTBEN_BIT];
    end
  end
endmodule

// ===== tb/tmr_pin_model.sv
// Model of the circuit on the half A output pad
`timescale 1ns/1ps
module tmr_pin_model (
  input wire logic hclk,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pad,
  output int toggles
);
  logic pad_prev = 1'b1;
  // Released pad pulled high, pin use optional
  assign pad = pin_oe ? pin_o : 1'b1;
  initial toggles = 0;
  always @(posedge hclk) begin
    if (pad !== pad_prev) begin
      toggles <= toggles + 1;
    end
    pad_prev <= pad;
  end
endmodule

// ===== tb/tmr_top_chk.sv
// Checker of pin, interrupt and bus relations of the timer
`timescale 1ns/1ps
module tmr_top_chk #(
  parameter bit LOW_POWER = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic half_a_pin_o,
  input wire logic half_a_pin_oe,
  input wire logic half_a_inverted_pin_o,
  input wire logic half_a_inverted_pin_oe,
  input wire logic half_b_pin_o,
  input wire logic half_b_inverted_pin_o,
  input wire logic irq
);
  logic ap_wr;
  logic [7:0] ap_ofs;
  logic [31:0] pc_reg;
  logic [31:0] sc_reg;
  logic pol_d;
  logic a_out;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Shadow of the control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr <= 1'b0;
      ap_ofs <= 8'h00;
      pc_reg <= 32'h0;
      sc_reg <= 32'h0;
    end else if (hready) begin
      ap_wr <= hsel & htrans[1] & hwrite;
      ap_ofs <= haddr[7:0];
      if (ap_wr && ap_ofs == tmr_pkg::OFS_PCTRL) begin
        pc_reg <= hwdata & tmr_pkg::PCTRL_WMASK;
      end
      if (ap_wr && ap_ofs == tmr_pkg::OFS_SCTRL) begin
        sc_reg <= hwdata & tmr_pkg::SCTRL_WMASK;
      end
    end
  end
  // Polarity that produced the present pin level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pol_d <= 1'b0;
    end else begin
      pol_d <= pc_reg[8];
    end
  end
  // Half A output as it leaves this instance
  assign a_out = LOW_POWER ? half_b_pin_o : half_a_pin_o;
  sequence s_pulse;
    pc_reg[3:0] == tmr_pkg::MODE_ONESHOT && $rose(a_out ^ pol_d);
  endsequence
  sequence s_shot_ie;
    s_pulse ##0 sc_reg[1];
  endsequence
  inv_a_comp_a: assert property (!LOW_POWER
    |-> half_a_inverted_pin_o == !half_a_pin_o)
    else $error("inverted A not complement");
  inv_b_comp_a: assert property (!LOW_POWER
    |-> half_b_inverted_pin_o == !half_b_pin_o)
    else $error("inverted B not complement");
  lp_a_off_a: assert property (LOW_POWER
    |-> !half_a_pin_oe && !half_a_inverted_pin_oe)
    else $error("low power drives A pins");
  oe_follow_a: assert property (!LOW_POWER |-> half_a_pin_oe == sc_reg[2])
    else $error("A enable wrong");
  inv_oe_a: assert property (!LOW_POWER |-> half_a_inverted_pin_oe == sc_reg[3])
    else $error("inverted A enable wrong");
  pulse_one_a: assert property (s_pulse |=> a_out == pol_d)
    else $error("pulse not one cycle");
  shot_irq_a: assert property (s_shot_ie |-> irq)
    else $error("no irq at pulse");
  cont_irq_a: assert property (pc_reg[3:0] == tmr_pkg::MODE_CONT && sc_reg[1]
    && $changed(a_out ^ pol_d) |-> irq)
    else $error("toggle without irq");
  irq_hold_a: assert property ($fell(irq) |-> $past(ap_wr))
    else $error("irq fell without write");
endmodule
bind tmr_top tmr_top_chk #(.LOW_POWER(LOW_POWER)) u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .half_a_pin_o, .half_a_pin_oe, .half_a_inverted_pin_o,
  .half_a_inverted_pin_oe, .half_b_pin_o, .half_b_inverted_pin_o, .irq);

// ===== tb/tmr_top_tb.sv
// Testbench of the timer in one-shot and continuous modes
`timescale 1ns/1ps
module tmr_top_tb;
  localparam logic [7:0] CNT = tmr_pkg::OFS_COUNT;
  localparam logic [7:0] CMP = tmr_pkg::OFS_COMPARE;
  localparam logic [7:0] PC = tmr_pkg::OFS_PCTRL;
  localparam logic [7:0] SC = tmr_pkg::OFS_SCTRL;
  localparam logic [7:0] FL = tmr_pkg::OFS_FLAGS;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, irq, pad_a;
  logic half_a_pin_o, half_a_pin_oe, half_a_inverted_pin_o, half_a_inverted_pin_oe;
  logic half_b_pin_o, half_b_pin_oe, half_b_inverted_pin_o, half_b_inverted_pin_oe;
  logic lp_b_o, lp_b_oe, lp_a_oe, lp_ai_oe, lp_bi_oe;
  int toggles, t;
  int mismatches = 0;
  int n_tests = 0;
  always #12.5 hclk = ~hclk;
  tmr_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .half_a_pin_o, .half_a_pin_oe,
    .half_a_inverted_pin_o, .half_a_inverted_pin_oe, .half_b_pin_o, .half_b_pin_oe,
    .half_b_inverted_pin_o, .half_b_inverted_pin_oe, .irq);
  tmr_pin_model u_pins (.hclk, .pin_o(half_a_pin_o), .pin_oe(half_a_pin_oe), .pad(pad_a),
    .toggles);
  // Low-power instance on the same bus, only its pins are watched
  tmr_top #(.LOW_POWER(1'b1)) DUT_LP (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata(), .hreadyout(), .hresp(),
    .half_a_pin_o(), .half_a_pin_oe(lp_a_oe), .half_a_inverted_pin_o(),
    .half_a_inverted_pin_oe(lp_ai_oe), .half_b_pin_o(lp_b_o), .half_b_pin_oe(lp_b_oe),
    .half_b_inverted_pin_o(), .half_b_inverted_pin_oe(lp_bi_oe), .irq());
  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic fail(input string m);
    mismatches++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) fail(m);
  endtask
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    q = hrdata;
    if (n >= 40) begin
      fail("bus hang");
      results();
    end
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    int i;
    for (i = 0; i < 50; i++) begin
      bus(0, a, 0);
      if (q[b] === 1'b1) break;
    end
    if (i == 50) begin
      fail("poll bound");
      results();
    end
  endtask
  task automatic wait_irq(input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge hclk);
      if (irq === 1'b1) break;
    end
    if (i == lim) begin
      fail("irq bound");
      results();
    end
  endtask
  task automatic t_reset;
    logic [7:0] ofs[6] = '{CNT, CMP, PC, SC, FL, 8'h40};
    bus(1, 8'h40, 32'hffff_ffff);
    foreach (ofs[i]) begin
      bus(0, ofs[i], 0);
      chk(q, 32'h0, "reset value");
    end
    chk(32'(hresp), 0, "okay response");
    chk(32'(half_a_pin_o), 0, "idle level");
    chk(32'(half_a_inverted_pin_o), 1, "inverted idle");
    $display("t_reset done");
  endtask
  task automatic t_gate;
    bus(1, CNT, 32'h7);
    bus(0, CNT, 0);
    chk(q, 32'h0, "count write gated");
    bus(1, PC, 32'h400);
    poll(SC, tmr_pkg::RDY_BIT);
    bus(1, CNT, 32'h5);
    poll(FL, tmr_pkg::WRDONE_BIT);
    bus(0, CNT, 0);
    chk(q, 32'h5, "count write");
    $display("t_gate done");
  endtask
  task automatic t_modes;
    logic [3:0] codes[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 14};
    foreach (codes[i]) begin
      bus(1, PC, 32'h400 | 32'(codes[i]));
      bus(0, PC, 0);
      chk(32'(q[3:0]), 32'(codes[i]), "mode field");
    end
    bus(1, PC, 32'h400);
    $display("t_modes done");
  endtask
  task automatic t_oneshot;
    bus(1, SC, 32'he);
    bus(1, CMP, 32'd40);
    bus(1, CNT, 32'd5);
    poll(FL, tmr_pkg::WRDONE_BIT);
    bus(1, FL, 32'hffff_ffff);
    t = toggles;
    bus(1, PC, 32'h600);
    poll(PC, tmr_pkg::EN_BIT);
    wait_irq(100);
    bus(0, PC, 0);
    chk(32'(q[9]), 0, "self disable");
    bus(0, CNT, 0);
    chk(q, tmr_pkg::CNT_RELOAD, "reload one");
    bus(0, FL, 0);
    chk(32'(q[0]), 1, "period flag");
    chk(32'(toggles - t), 2, "single pulse");
    bus(1, FL, 32'h1);
    @(posedge hclk);
    chk(32'(irq), 0, "flag clear");
    $display("t_oneshot done");
  endtask
  task automatic t_cont;
    bus(1, PC, 32'h500);
    repeat (2) @(posedge hclk);
    chk(32'(half_a_pin_o), 1, "polarity idle");
    chk(32'(half_a_inverted_pin_o), 0, "inverted polarity");
    chk(32'(lp_b_o), 1, "low power pin on B");
    chk(32'(lp_b_oe), 1, "low power enable on B");
    chk(32'({lp_a_oe, lp_ai_oe, lp_bi_oe}), 0, "low power other pins");
    bus(1, CMP, 32'd3);
    t = toggles;
    bus(1, PC, 32'h701);
    poll(PC, tmr_pkg::EN_BIT);
    wait_irq(50);
    bus(1, FL, 32'h1);
    repeat (20) @(posedge hclk);
    bus(0, PC, 0);
    chk(32'(q[9]), 1, "still running");
    chk(32'(toggles - t >= 4), 1, "toggle each period");
    bus(0, CNT, 0);
    chk(32'(q >= 1 && q <= 3), 1, "count range");
    bus(1, SC, 32'h4);
    repeat (10) @(posedge hclk);
    chk(32'(irq), 0, "masked request");
    bus(0, FL, 0);
    chk(32'(q[0]), 1, "flag still set");
    bus(1, PC, 32'h400);
    $display("t_cont done");
  endtask
  task automatic t_cascade;
    bus(1, SC, 32'h8000_0006);
    bus(1, CMP, 32'h0001_0040);
    bus(1, CNT, 32'h0000_fff0);
    poll(FL, tmr_pkg::WRDONE_BIT);
    bus(1, FL, 32'hffff_ffff);
    bus(1, PC, 32'h600);
    poll(PC, tmr_pkg::EN_BIT);
    repeat (40) @(posedge hclk);
    bus(0, CNT, 0);
    chk(32'(q[31:16]), 1, "carry into upper half");
    chk(32'({half_b_pin_o, half_b_pin_oe, half_b_inverted_pin_o, half_b_inverted_pin_oe}),
      32'h2, "half B idle in cascade");
    wait_irq(100);
    $display("t_cascade done");
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_gate();
    t_modes();
    t_oneshot();
    t_cont();
    t_cascade();
    results();
  end
endmodule
